// >>> common/ecc_accel_pkg.sv
// constants and types shared by the elliptic-curve accelerator control files
`default_nettype none
package ecc_accel_pkg;
  // byte offsets inside the accelerator address window
  localparam int ADDR_W = 12;
  localparam logic [11:0] CMD_STATUS_OFFSET = 12'h000;
  localparam logic [11:0] EVENT_FLAGS_OFFSET = 12'h004;
  localparam logic [11:0] EVENT_ENABLES_OFFSET = 12'h008;
  localparam logic [11:0] RAM_BASE = 12'h400;
  // command/status fields
  localparam int LAUNCH_BIT = 0;
  localparam int READY_BIT = 1;
  localparam int SOFT_RESET_BIT = 7;
  // event flag and enable fields
  localparam int DONE_BIT = 0;
  localparam int BUSY_MEM_BIT = 2;
  localparam int UNMAPPED_BIT = 3;
  localparam int EVENT_W = 4;
  localparam logic [3:0] EVENT_MASK = 4'hD;
  // reset values
  localparam logic [31:0] CMD_STATUS_RESET = 32'h00000002;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] ENABLES_RESET = 4'h0;
  // bus transfer type: bit 1 marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;
  // core clock is the system clock divided by this figure
  localparam int CORE_CLOCK_DIVIDE = 2;
  localparam int RAM_WORDS_DEFAULT = 256;
  localparam int COMPUTE_CYCLES_DEFAULT = 64;

  typedef enum logic [1:0] {
    REGION_REG = 2'h0,
    REGION_RAM = 2'h1,
    REGION_UNMAPPED = 2'h2
  } region_type;

  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_WRITE = 6'h02,
    PH_READ_WAIT = 6'h04,
    PH_READ_DONE = 6'h08,
    PH_ERROR_1 = 6'h10,
    PH_ERROR_2 = 6'h20
  } phase_type;
endpackage : ecc_accel_pkg
`default_nettype wire

// >>> hdl/ecc_engine.sv
// sequencer of the accelerator core on the divided core clock enable
`timescale 1ns/1ps
`default_nettype none
module ecc_engine
  import ecc_accel_pkg::*;
#(
  parameter int COMPUTE_CYCLES = COMPUTE_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic launch,
  output logic ready
);
  localparam int CNT_W = $clog2(COMPUTE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COMPUTE_CYCLES - 1);
  localparam logic [3:0] DIV_LAST = 4'(CORE_CLOCK_DIVIDE - 1);

  generate
    if (COMPUTE_CYCLES < 1 || CORE_CLOCK_DIVIDE < 2 || CORE_CLOCK_DIVIDE > 16)
    begin : g_bad_param
      $error("ecc_engine: unsupported cycle count or divider");
    end
  endgenerate

  logic [3:0] div_cnt;
  logic core_en;
  logic [CNT_W-1:0] run_cnt;

  // one enable pulse every second system clock drives the core
  assign core_en = (div_cnt == DIV_LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= 4'h0;
    end else if (soft_reset || core_en) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // soft reset aborts a running computation and leaves the core ready
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready <= 1'b1;
      run_cnt <= '0;
    end else if (soft_reset) begin
      ready <= 1'b1;
      run_cnt <= '0;
    end else if (launch && ready) begin
      ready <= 1'b0;
      run_cnt <= '0;
    end else if (!ready && core_en) begin
      if (run_cnt == CNT_LAST) begin
        ready <= 1'b1;
      end else begin
        run_cnt <= run_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  chk_core_rate: assert property (@(posedge mclk) disable iff (rst)
    core_en |=> !core_en)
    else $error("core enable ran faster than half the system clock");
endmodule : ecc_engine
`default_nettype wire

// >>> hdl/ecc_accel_ctrl_irq.sv
// control, status and event logic of the elliptic-curve accelerator
// Summary of operation
// - A one written to the launch bit starts a computation; a zero does nothing.
// - The ready bit reads zero while computing, one when idle, and resets to one.
// - Each rising edge of ready at the end of a computation sets the process-done flag; a soft reset abort does not.
// - A one written to the soft reset bit resets the engine, the flags and the enables; the RAM keeps its data.
// - The process-done flag reads one after a computation and clears on a one.
// - Bus access to the RAM while computing fails and sets the busy-memory flag.
// - A one written to the busy-memory flag clears it; a zero leaves it.
// - Access to unmapped RAM-range space sets the unmapped flag; a one clears it.
// - The enable register holds one enable per event and resets to zero.
// - The core runs on the system clock divided by two, the RAM on the full clock.
`timescale 1ns/1ps
`default_nettype none
module ecc_accel_ctrl_irq
  import ecc_accel_pkg::*;
#(
  parameter int RAM_WORDS = RAM_WORDS_DEFAULT,
  parameter int COMPUTE_CYCLES = COMPUTE_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);
  localparam int IDX_W = $clog2(RAM_WORDS);
  localparam logic [11:0] RAM_LIMIT = RAM_BASE + 12'(RAM_WORDS * 4);

  generate
    if (RAM_WORDS < 2 || RAM_WORDS > 256 || (1 << IDX_W) != RAM_WORDS)
    begin : g_bad_param
      $error("ecc_accel_ctrl_irq: RAM_WORDS must be a power of two to 256");
    end
  endgenerate

  function automatic region_type region_of(input logic [11:0] a);
    if (a < RAM_BASE) begin
      return REGION_REG;
    end else if (a < RAM_LIMIT) begin
      return REGION_RAM;
    end else begin
      return REGION_UNMAPPED;
    end
  endfunction : region_of

  phase_type phase;
  region_type region_now;
  region_type region_q;
  logic [11:0] addr_q;
  logic take;
  logic ready;
  logic ready_prev;
  logic ready_rise;
  logic launch;
  logic sw_rst;
  logic ram_blocked;
  logic busy_hit;
  logic unmapped_hit;
  logic wr_cmd;
  logic wr_flags;
  logic wr_enables;
  logic [3:0] flags;
  logic [3:0] enables;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [31:0] read_value;
  logic [31:0] ram [RAM_WORDS];
  logic [IDX_W-1:0] ram_idx;

  // ---------------- bus address and data phases ----------------
  assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
  assign region_now = region_of(haddr[ADDR_W-1:0]);
  // a launch written in the current data phase already locks the RAM
  assign ram_blocked = !ready || launch;
  assign busy_hit = take && (region_now == REGION_RAM) && ram_blocked;
  assign unmapped_hit = take && (region_now == REGION_UNMAPPED);
  assign hreadyout = !(phase == PH_READ_WAIT || phase == PH_ERROR_1);
  assign hresp = (phase == PH_ERROR_1) || (phase == PH_ERROR_2);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= PH_IDLE;
      addr_q <= 12'h000;
      region_q <= REGION_REG;
    end else begin
      case (phase)
        PH_READ_WAIT: begin
          phase <= PH_READ_DONE;
        end
        PH_ERROR_1: begin
          phase <= PH_ERROR_2;
        end
        default: begin
          if (take) begin
            addr_q <= haddr[ADDR_W-1:0];
            region_q <= region_now;
            if (busy_hit || unmapped_hit) begin
              phase <= PH_ERROR_1;
            end else if (hwrite) begin
              phase <= PH_WRITE;
            end else begin
              phase <= PH_READ_WAIT;
            end
          end else begin
            phase <= PH_IDLE;
          end
        end
      endcase
    end
  end

  assign wr_cmd = (phase == PH_WRITE) && (addr_q == CMD_STATUS_OFFSET);
  assign wr_flags = (phase == PH_WRITE) && (addr_q == EVENT_FLAGS_OFFSET);
  assign wr_enables = (phase == PH_WRITE) && (addr_q == EVENT_ENABLES_OFFSET);
  assign ram_idx = addr_q[IDX_W+1:2];

  // ---------------- command and soft reset ----------------
  // soft reset in the same word wins over launch
  assign launch = wr_cmd && hwdata[LAUNCH_BIT] && ready
    && !hwdata[SOFT_RESET_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sw_rst <= 1'b0;
    end else begin
      sw_rst <= wr_cmd && hwdata[SOFT_RESET_BIT];
    end
  end

  ecc_engine #(
    .COMPUTE_CYCLES(COMPUTE_CYCLES)
  ) u_engine (
    .mclk(mclk),
    .rst(rst),
    .soft_reset(sw_rst),
    .launch(launch),
    .ready(ready)
  );

  // ready_prev forced high on soft reset so an abort raises no done event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready_prev <= 1'b1;
    end else if (sw_rst) begin
      ready_prev <= 1'b1;
    end else begin
      ready_prev <= ready;
    end
  end

  assign ready_rise = ready && !ready_prev;

  // ---------------- event flags, enables, interrupt ----------------
  always_comb begin
    flag_set = 4'h0;
    flag_set[DONE_BIT] = ready_rise;
    flag_set[BUSY_MEM_BIT] = busy_hit;
    flag_set[UNMAPPED_BIT] = unmapped_hit;
  end

  assign flag_clr = wr_flags ? (hwdata[EVENT_W-1:0] & EVENT_MASK) : 4'h0;

  // a set in the same cycle as its clear wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else if (sw_rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enables <= ENABLES_RESET;
    end else if (sw_rst) begin
      enables <= ENABLES_RESET;
    end else if (wr_enables) begin
      enables <= hwdata[EVENT_W-1:0] & EVENT_MASK;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & enables);
    end
  end

  // ---------------- dedicated RAM and read data ----------------
  // RAM runs on the full system clock; no reset, contents are data only
  always_ff @(posedge mclk) begin
    if (phase == PH_WRITE && region_q == REGION_RAM) begin
      ram[ram_idx] <= hwdata;
    end
  end

  always_comb begin
    read_value = 32'h00000000;
    if (region_q == REGION_RAM) begin
      read_value = ram[ram_idx];
    end else if (addr_q == CMD_STATUS_OFFSET) begin
      read_value[READY_BIT] = ready;
    end else if (addr_q == EVENT_FLAGS_OFFSET) begin
      read_value[EVENT_W-1:0] = flags;
    end else if (addr_q == EVENT_ENABLES_OFFSET) begin
      read_value[EVENT_W-1:0] = enables;
    end
  end

  // the wait state lets hrdata come from a flop and see any prior write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (phase == PH_READ_WAIT) begin
      hrdata <= read_value;
    end
  end

  // ---------------- checks ----------------
  chk_launch_drops_ready: assert property (
    @(posedge mclk) disable iff (rst)
    launch |=> !ready ##1 !ready)
    else $error("launch did not clear ready");

  chk_zero_no_launch: assert property (
    @(posedge mclk) disable iff (rst)
    wr_cmd && !hwdata[LAUNCH_BIT] && !hwdata[SOFT_RESET_BIT] && ready
    |=> ready)
    else $error("zero launch bit started the engine");

  chk_ready_readback: assert property (
    @(posedge mclk) disable iff (rst)
    phase == PH_READ_WAIT && addr_q == CMD_STATUS_OFFSET
    |=> hrdata[READY_BIT] == $past(ready) && hreadyout)
    else $error("ready bit read back wrong");

  chk_done_on_rise: assert property (
    @(posedge mclk) disable iff (rst)
    ready_rise && !sw_rst |=> flags[DONE_BIT])
    else $error("ready rise did not set done flag");

  chk_soft_reset_all: assert property (
    @(posedge mclk) disable iff (rst)
    wr_cmd && hwdata[SOFT_RESET_BIT]
    |=> ##1 flags == FLAGS_RESET && enables == ENABLES_RESET && ready)
    else $error("soft reset did not clear the peripheral");

  chk_done_clear: assert property (
    @(posedge mclk) disable iff (rst)
    wr_flags && hwdata[DONE_BIT] && !ready_rise |=> !flags[DONE_BIT])
    else $error("done flag not cleared by one");

  chk_busy_error: assert property (
    @(posedge mclk) disable iff (rst)
    busy_hit |=> hresp && !hreadyout && flags[BUSY_MEM_BIT]
    ##1 hresp && hreadyout)
    else $error("busy RAM access not refused");

  chk_busy_clear: assert property (
    @(posedge mclk) disable iff (rst)
    wr_flags && hwdata[BUSY_MEM_BIT] && !busy_hit |=> !flags[BUSY_MEM_BIT])
    else $error("busy-memory flag not cleared by one");

  chk_unmapped_keep: assert property (
    @(posedge mclk) disable iff (rst)
    wr_flags && flags[UNMAPPED_BIT] && !hwdata[UNMAPPED_BIT] && !sw_rst
    |=> flags[UNMAPPED_BIT])
    else $error("zero write disturbed unmapped flag");

  chk_unmapped_set: assert property (
    @(posedge mclk) disable iff (rst)
    unmapped_hit |=> flags[UNMAPPED_BIT] && hresp)
    else $error("unmapped access not flagged");

  chk_enable_store: assert property (
    @(posedge mclk) disable iff (rst)
    wr_enables && !sw_rst |=> enables == ($past(hwdata[3:0]) & EVENT_MASK))
    else $error("enable register did not store write");

  chk_irq_gating: assert property (
    @(posedge mclk) disable iff (rst)
    (flags & enables) == 4'h0 |=> !irq)
    else $error("interrupt raised with no enabled flag");

  cov_launch: cover property (@(posedge mclk) disable iff (rst) launch);
  cov_done: cover property (@(posedge mclk) disable iff (rst)
    ready_rise && !sw_rst);
  cov_busy: cover property (@(posedge mclk) disable iff (rst) busy_hit);
  cov_unmapped: cover property (@(posedge mclk) disable iff (rst)
    unmapped_hit);
endmodule : ecc_accel_ctrl_irq
`default_nettype wire

// >>> testbench/ahb_master_model.sv
// bus master model standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
  input wire logic mclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
  end
  // whole words only, one transfer in flight; lines scrambled after use
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 8);
    // a reply that never came shows as unknown so the caller's check trips
    rd = (hreadyout === 1'h1) ? hrdata : 'x;
    err = (hreadyout === 1'h1) ? hresp : 1'bx;
    haddr <= ~a;
    hwdata <= ~d;
  endtask : xfer
endmodule : ahb_master_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench of the accelerator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ecc_accel_pkg::*;
  localparam int CYC = 16;
  localparam int WORDS = 16;
  localparam logic [31:0] CS = {20'h0, CMD_STATUS_OFFSET};
  localparam logic [31:0] FL = {20'h0, EVENT_FLAGS_OFFSET};
  localparam logic [31:0] EN = {20'h0, EVENT_ENABLES_OFFSET};
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic hsel, hwrite, hreadyout, hresp, irq, err;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, mem0;
  int n_fail = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  ecc_accel_ctrl_irq #(.RAM_WORDS(WORDS), .COMPUTE_CYCLES(CYC))
    ecc_accel_ctrl_irq_i (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
  ahb_master_model ahb_master_model_i (.mclk(mclk), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  function automatic logic [31:0] exp_irq(input logic [3:0] f,
    input logic [3:0] e);
    return {31'h0, |(f & e & EVENT_MASK)};
  endfunction : exp_irq
  function automatic logic [31:0] ram_addr(input int k);
    return {20'h0, RAM_BASE} + 32'(4 * k);
  endfunction : ram_addr
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb_master_model_i.xfer(1'h1, a, d, rd, err);
    check({31'h0, err}, 32'h0, "write okay");
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
    input string msg);
    ahb_master_model_i.xfer(1'h0, a, 32'h0, rd, err);
    check(rd, e, msg);
  endtask : rd_chk
  // polling is bounded so a stuck engine cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      ahb_master_model_i.xfer(1'h0, CS, 32'h0, rd, err);
      n++;
    end while (rd[READY_BIT] !== 1'h1 && n < 100);
    check({31'h0, rd[READY_BIT]}, 32'h1, "ready in time");
  endtask : wait_ready
  task automatic final_report();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    logic [3:0] en;
    int k;
    void'($urandom(30));
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    rd_chk(CS, CMD_STATUS_RESET, "cs reset");
    rd_chk(FL, 32'h0, "flags reset");
    rd_chk(EN, 32'h0, "enables reset");
    rd_chk(CS + 32'hC, 32'h0, "reserved offset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      en = 4'($urandom) & EVENT_MASK;
      wr(EN, {28'h0, en});
      rd_chk(EN, {28'h0, en}, "enables");
    end
    $display("test enables done");
    mem0 = $urandom;
    wr(ram_addr(3), mem0);
    wr(EN, 32'hD);
    wr(CS, 32'h1);
    rd_chk(CS, 32'h0, "busy status");
    ahb_master_model_i.xfer(1'h1, ram_addr(3), ~mem0, rd, err);
    check({31'h0, err}, 32'h1, "busy access");
    ahb_master_model_i.xfer(1'h0, ram_addr(3), 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "busy read");
    wr(CS, 32'h0);
    wait_ready();
    rd_chk(FL, 32'h5, "done and busy flags");
    check({31'h0, irq}, exp_irq(4'h5, 4'hD), "irq set");
    rd_chk(ram_addr(3), mem0, "ram untouched");
    wr(FL, 32'h0);
    rd_chk(FL, 32'h5, "zero write");
    wr(FL, 32'h4);
    rd_chk(FL, 32'h1, "busy cleared");
    wr(FL, 32'h1);
    wr(FL, 32'h0);
    rd_chk(FL, 32'h0, "done cleared");
    check({31'h0, irq}, exp_irq(4'h0, 4'hD), "irq clear");
    wr(CS, 32'h0);
    rd_chk(CS, 32'h2, "zero launch");
    $display("test launch done");
    ahb_master_model_i.xfer(1'h0, ram_addr(WORDS), 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "unmapped error");
    rd_chk(FL, 32'h8, "unmapped flag");
    check({31'h0, irq}, exp_irq(4'h8, 4'hD), "irq unmapped");
    wr(EN, 32'h4);
    rd_chk(EN, 32'h4, "mask");
    check({31'h0, irq}, exp_irq(4'h8, 4'h4), "irq masked");
    wr(FL, 32'h8);
    wr(FL, 32'h0);
    rd_chk(FL, 32'h0, "unmapped cleared");
    for (int i = 0; i < 4; i++) begin
      mem0 = $urandom;
      k = $urandom_range(WORDS - 1);
      wr(ram_addr(k), mem0);
      ahb_master_model_i.xfer(1'h0, ram_addr(k), 32'h0, rd, err);
      check(rd, mem0, "ram word");
      check({31'h0, err}, 32'h0, "ram okay");
    end
    $display("test memory done");
    wr(EN, 32'hD);
    wr(CS, 32'h1);
    wr(CS, 32'h80);
    wr(CS, 32'h0);
    rd_chk(CS, 32'h2, "soft reset ready");
    rd_chk(EN, 32'h0, "soft reset enables");
    rd_chk(FL, 32'h0, "soft reset flags");
    check({31'h0, irq}, exp_irq(4'h0, 4'h0), "irq soft reset");
    wr(CS, 32'h81);
    wr(CS, 32'h0);
    rd_chk(CS, 32'h2, "soft reset beats launch");
    $display("test soft reset done");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
endmodule : testbench
`default_nettype wire
